// ==== emulation_map_config.sv ====
// Purpose: emulation map configuration registers and address decode
// Assumes: cpu and pci address inputs from pclk-domain logic
// Notes:   pins debug_config_bit, map_select, tracking_state synchronised
`timescale 1ns/1ps
`default_nettype none
module emulation_map_config (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// external configuration pins
	input  wire logic        debug_config_bit,
	input  wire logic        map_select,
	input  wire logic [1:0]  tracking_state,
	// processor bus request
	input  wire logic        cpu_valid,
	input  wire logic [31:0] cpu_addr,
	output logic      [31:0] cpu_addr_out,
	output logic             cpu_to_pci,
	output logic             cpu_out_valid,
	// pci target request
	input  wire logic        pci_valid,
	input  wire logic        pci_write,
	input  wire logic [31:0] pci_addr,
	output logic             pci_claim,
	output logic      [31:0] pci_mem_addr,
	// interrupts
	output logic             programmable_irq_out,
	output logic             irq
);
	logic [31:0] cfg_one_reg;
	logic [31:0] cfg_two_reg;
	logic [2:0]  status_reg;
	logic [2:0]  mask_reg;
	logic [3:0]  pin_sync;
	logic [1:0]  track_s;
	logic        dbg_s;
	logic        sel_s;
	logic        wr_en;
	logic        rd_en;
	logic        mapped;
	logic [1:0]  map_mode;
	logic        emu_on;
	logic        wirq_event;
	logic        bad_size_event;
	logic        pci_hit;
	logic [31:0] pci_xlat;
	logic [31:0] cpu_xlat;
	logic        cpu_pci;

	irq_sync #(.WIDTH(4)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({debug_config_bit, map_select, tracking_state}),
		.sync_out (pin_sync)
	);
	assign dbg_s   = pin_sync[3];
	assign sel_s   = pin_sync[2];
	assign track_s = pin_sync[1:0];

	function automatic logic in_range(input logic [31:0] a,
		input logic [31:0] lo, input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic size_ok(input logic [7:0] s);
		size_ok = (s == emulation_map_pkg::SIZE_8K) ||
			(s == emulation_map_pkg::SIZE_4K);
	endfunction

	// apb access phase, zero wait
	assign wr_en  = psel && penable && pwrite;
	assign rd_en  = psel && penable && !pwrite;
	assign mapped = (paddr == emulation_map_pkg::CFG_ONE_OFFSET) ||
		(paddr == emulation_map_pkg::CFG_TWO_OFFSET) ||
		(paddr == emulation_map_pkg::IRQ_STATUS_OFFSET) ||
		(paddr == emulation_map_pkg::IRQ_MASK_OFFSET);

	// map selection: enable bit wins unless debug_config_bit is set, else pin selects a or b
	always_comb begin
		emu_on = cfg_one_reg[emulation_map_pkg::EMU_EN_BIT] && !dbg_s;
		if (emu_on)
			map_mode = emulation_map_pkg::MAP_EMU;
		else if (sel_s)
			map_mode = emulation_map_pkg::MAP_B;
		else
			map_mode = emulation_map_pkg::MAP_A;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_one_reg <= emulation_map_pkg::CFG_ONE_RESET;
			cfg_two_reg <= emulation_map_pkg::CFG_TWO_RESET;
		end else if (wr_en && paddr == emulation_map_pkg::CFG_ONE_OFFSET) begin
			// capability bit forced, reserved masked
			cfg_one_reg <= (pwdata & emulation_map_pkg::CFG_ONE_WMASK) |
				(32'h0000_0001 << emulation_map_pkg::CAPABLE_BIT);
		end else if (wr_en && paddr == emulation_map_pkg::CFG_TWO_OFFSET) begin
			cfg_two_reg <= pwdata & emulation_map_pkg::CFG_TWO_WMASK;
		end
	end

	// pci target decode and translation
	always_comb begin
		pci_hit  = 1'b0;
		pci_xlat = pci_addr;
		case (map_mode)
			emulation_map_pkg::MAP_EMU: begin
				pci_hit = (pci_addr[31:20] <= {4'h0,
					cfg_one_reg[emulation_map_pkg::LIMIT_LSB +: 8]});
				if (cfg_one_reg[emulation_map_pkg::PCI_HOLE_BIT] &&
					in_range(pci_addr, emulation_map_pkg::HOLE_BASE,
					emulation_map_pkg::PCI_HOLE_END))
					pci_hit = 1'b0;
			end
			emulation_map_pkg::MAP_B: begin
				pci_hit = (pci_addr[31] == 1'b0);
				if (cfg_one_reg[emulation_map_pkg::PCI_HOLE_BIT] &&
					in_range(pci_addr, emulation_map_pkg::HOLE_BASE,
					emulation_map_pkg::PCI_HOLE_END))
					pci_hit = 1'b0;
				if (pci_addr[31:24] == emulation_map_pkg::ALIAS_TOP) begin
					pci_hit  = cfg_one_reg[emulation_map_pkg::ALIAS_BIT];
					pci_xlat = {8'h00, pci_addr[23:0]};
				end
			end
			default: pci_hit = (pci_addr[31] == 1'b1);
		endcase
	end

	// processor decode: relocation and legacy hole
	always_comb begin
		cpu_xlat = cpu_addr;
		cpu_pci  = 1'b0;
		if (map_mode == emulation_map_pkg::MAP_EMU &&
			cpu_addr[31:20] == emulation_map_pkg::BOOT_TOP)
			cpu_xlat = {cfg_one_reg[emulation_map_pkg::RELOC_LSB +: 12],
				cpu_addr[19:0]};
		if (map_mode != emulation_map_pkg::MAP_A &&
			in_range(cpu_addr, emulation_map_pkg::HOLE_BASE,
			emulation_map_pkg::CPU_HOLE_END))
			cpu_pci = cfg_one_reg[emulation_map_pkg::CPU_HOLE_BIT];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_addr_out  <= '0;
			cpu_to_pci    <= 1'b0;
			cpu_out_valid <= 1'b0;
			pci_claim     <= 1'b0;
			pci_mem_addr  <= '0;
		end else begin
			cpu_addr_out  <= cpu_xlat;
			cpu_to_pci    <= cpu_valid && cpu_pci;
			cpu_out_valid <= cpu_valid;
			pci_claim     <= pci_valid && pci_hit;
			pci_mem_addr  <= pci_xlat;
		end
	end

	// write to memory while nothing tracked
	assign wirq_event = emu_on &&
		cfg_one_reg[emulation_map_pkg::WIRQ_EN_BIT] &&
		pci_valid && pci_write && pci_hit &&
		track_s == emulation_map_pkg::TRACK_NONE;
	assign bad_size_event = !size_ok(cfg_two_reg[7:0]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			programmable_irq_out <= 1'b1;
		end else begin
			programmable_irq_out <= wirq_event ~^
				cfg_one_reg[emulation_map_pkg::POL_BIT];
		end
	end

	// sticky status, write one clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= '0;
			mask_reg   <= '0;
		end else begin
			if (wr_en && paddr == emulation_map_pkg::IRQ_STATUS_OFFSET)
				status_reg <= (status_reg & ~pwdata[2:0]) |
					{pci_claim, bad_size_event, wirq_event};
			else
				status_reg <= status_reg |
					{pci_claim, bad_size_event, wirq_event};
			if (wr_en && paddr == emulation_map_pkg::IRQ_MASK_OFFSET)
				mask_reg <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_reg & mask_reg);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= '0;
			if (psel && !pwrite && !penable) begin
				case (paddr)
					emulation_map_pkg::CFG_ONE_OFFSET: prdata <= cfg_one_reg;
					emulation_map_pkg::CFG_TWO_OFFSET: prdata <= cfg_two_reg;
					emulation_map_pkg::IRQ_STATUS_OFFSET:
						prdata <= {29'h0, status_reg};
					emulation_map_pkg::IRQ_MASK_OFFSET:
						prdata <= {29'h0, mask_reg};
					default: prdata <= '0;
				endcase
			end
		end
	end

	// register checks
	a_capable_one: assert property (
		@(posedge pclk) disable iff (!presetn)
		cfg_one_reg[emulation_map_pkg::CAPABLE_BIT])
		else $error("capability bit not one");
	a_reserved_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		cfg_one_reg[31:28] == 4'h0 && !cfg_one_reg[7] &&
		cfg_two_reg[31:8] == 24'h0)
		else $error("reserved bits nonzero");
	a_setup_ready: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready)
		else $error("no ready after setup");
	a_unmapped_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !mapped |=> pslverr)
		else $error("no error on unmapped access");

	// decode checks
	a_reloc_addr: assert property (
		@(posedge pclk) disable iff (!presetn)
		cpu_valid && map_mode == emulation_map_pkg::MAP_EMU &&
		cpu_addr[31:20] == 12'hfff |=> cpu_addr_out ==
		{$past(cfg_one_reg[27:16]), $past(cpu_addr[19:0])})
		else $error("boot block relocation wrong");
	a_no_reloc: assert property (
		@(posedge pclk) disable iff (!presetn)
		cpu_valid && map_mode != emulation_map_pkg::MAP_EMU |=>
		cpu_addr_out == $past(cpu_addr))
		else $error("address changed outside emulation");
	a_limit_claim: assert property (
		@(posedge pclk) disable iff (!presetn)
		pci_valid && map_mode == emulation_map_pkg::MAP_EMU &&
		pci_addr[31:20] > {4'h0, cfg_one_reg[15:8]} |=> !pci_claim)
		else $error("claim above upper limit");
	a_alias_map: assert property (
		@(posedge pclk) disable iff (!presetn)
		pci_valid && map_mode == emulation_map_pkg::MAP_B &&
		pci_addr[31:24] == 8'hfd |=> pci_claim == $past(cfg_one_reg[6])
		&& pci_mem_addr[31:24] == 8'h00)
		else $error("alias window wrong");
	a_pci_hole: assert property (
		@(posedge pclk) disable iff (!presetn)
		pci_valid && map_mode != emulation_map_pkg::MAP_A &&
		cfg_one_reg[3] && pci_addr >= 32'h000a_0000 &&
		pci_addr <= 32'h000f_ffff |=> !pci_claim)
		else $error("pci hole claimed");
	a_cpu_hole: assert property (
		@(posedge pclk) disable iff (!presetn)
		cpu_valid && map_mode != emulation_map_pkg::MAP_A &&
		cpu_addr >= 32'h000a_0000 && cpu_addr <= 32'h000b_ffff
		|=> cpu_to_pci == $past(cfg_one_reg[2]))
		else $error("cpu hole routing wrong");
	a_map_select: assert property (
		@(posedge pclk) disable iff (!presetn)
		cfg_one_reg[0] && !dbg_s |-> map_mode == emulation_map_pkg::MAP_EMU)
		else $error("map select wrong");
	a_map_pins: assert property (
		@(posedge pclk) disable iff (!presetn)
		!emu_on |-> map_mode ==
		(sel_s ? emulation_map_pkg::MAP_B : emulation_map_pkg::MAP_A))
		else $error("standard map select wrong");

	// interrupt checks
	a_irq_level: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 programmable_irq_out == ($past(cfg_one_reg[4]) ?
		$past(wirq_event) : !$past(wirq_event)))
		else $error("programmable irq level wrong");
	a_write_irq: assert property (
		@(posedge pclk) disable iff (!presetn)
		emu_on && cfg_one_reg[emulation_map_pkg::WIRQ_EN_BIT] &&
		pci_valid && pci_write && pci_hit && track_s == 2'b00
		|=> programmable_irq_out == $past(cfg_one_reg[4]))
		else $error("write interrupt missing");
	a_tracked_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		track_s != emulation_map_pkg::TRACK_NONE |=>
		programmable_irq_out == !$past(cfg_one_reg[4]))
		else $error("interrupt while blocks tracked");
	a_size_status: assert property (
		@(posedge pclk) disable iff (!presetn)
		!size_ok(cfg_two_reg[7:0]) |=> status_reg[1])
		else $error("unsupported size not flagged");
	a_irq_follows: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 irq == ($past(status_reg & mask_reg) != 3'b000))
		else $error("interrupt line wrong");

	// coverage of main scenarios
	c_reloc: cover property (@(posedge pclk) disable iff (!presetn)
		cpu_valid && map_mode == emulation_map_pkg::MAP_EMU &&
		cpu_addr[31:20] == 12'hfff);
	c_wirq: cover property (@(posedge pclk) disable iff (!presetn)
		wirq_event);
	c_alias: cover property (@(posedge pclk) disable iff (!presetn)
		pci_valid && pci_addr[31:24] == 8'hfd && pci_hit);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
	c_cpu_hole: cover property (@(posedge pclk) disable iff (!presetn)
		cpu_valid && map_mode != emulation_map_pkg::MAP_A && cpu_pci);
endmodule // emulation_map_config
`default_nettype wire

// ==== emulation_map_pkg.sv ====
// Purpose: constants for the emulation map configuration block
// Assumes: apb slave, 32-bit data, byte addresses
// Notes:   offsets are byte addresses
package emulation_map_pkg;
	localparam logic [7:0]  CFG_ONE_OFFSET = 8'he0;
	localparam logic [7:0]  CFG_TWO_OFFSET = 8'he8;
	localparam logic [7:0]  IRQ_STATUS_OFFSET = 8'hf0;
	localparam logic [7:0]  IRQ_MASK_OFFSET = 8'hf4;
	localparam logic [31:0] CFG_ONE_RESET = 32'h0fff_0042;
	localparam logic [31:0] CFG_ONE_WMASK = 32'h0fff_ff7d;
	localparam logic [31:0] CFG_TWO_RESET = 32'h0000_0020;
	localparam logic [31:0] CFG_TWO_WMASK = 32'h0000_00ff;
	localparam int RELOC_LSB = 16;
	localparam int LIMIT_LSB = 8;
	localparam int ALIAS_BIT = 6;
	localparam int WIRQ_EN_BIT = 5;
	localparam int POL_BIT = 4;
	localparam int PCI_HOLE_BIT = 3;
	localparam int CPU_HOLE_BIT = 2;
	localparam int CAPABLE_BIT = 1;
	localparam int EMU_EN_BIT = 0;
	localparam logic [11:0] BOOT_TOP = 12'hfff;
	localparam logic [7:0]  ALIAS_TOP = 8'hfd;
	localparam logic [31:0] HOLE_BASE = 32'h000a_0000;
	localparam logic [31:0] PCI_HOLE_END = 32'h000f_ffff;
	localparam logic [31:0] CPU_HOLE_END = 32'h000b_ffff;
	localparam logic [7:0]  SIZE_8K = 8'h20;
	localparam logic [7:0]  SIZE_4K = 8'h10;
	localparam logic [1:0]  TRACK_NONE = 2'b00;
	localparam logic [1:0]  MAP_A = 2'b00;
	localparam logic [1:0]  MAP_B = 2'b01;
	localparam logic [1:0]  MAP_EMU = 2'b10;
endpackage

// ==== irq_sync.sv ====
// Purpose: two-flop synchroniser for external event pins
// Assumes: inputs asynchronous to pclk
// Notes:   first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module irq_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_reg <= '0;
			sync_out  <= '0;
		end else begin
			stage_reg <= async_in;
			sync_out  <= stage_reg;
		end
	end
endmodule // irq_sync
`default_nettype wire

// ==== far_side_model.sv ====
// Purpose: processor and pci master model for the decode ports
// Assumes: one request per call, launched after a rising edge
// Notes:   released address lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
	// clock
	input  wire logic        pclk,
	// processor bus master
	output logic             cpu_valid,
	output logic      [31:0] cpu_addr,
	// pci master
	output logic             pci_valid,
	output logic             pci_write,
	output logic      [31:0] pci_addr
);
	initial begin
		cpu_valid = 1'b0;
		cpu_addr = 32'h0000_0000;
		pci_valid = 1'b0;
		pci_write = 1'b0;
		pci_addr = 32'h0000_0000;
	end
	task automatic cpu_req(input logic [31:0] a);
		@(posedge pclk);
		cpu_valid <= 1'b1;
		cpu_addr <= a;
		@(posedge pclk);
		cpu_valid <= 1'b0;
		cpu_addr <= ~a;
	endtask
	task automatic pci_req(input logic [31:0] a, input logic wr);
		@(posedge pclk);
		pci_valid <= 1'b1;
		pci_write <= wr;
		pci_addr <= a;
		@(posedge pclk);
		pci_valid <= 1'b0;
		pci_write <= ~wr;
		pci_addr <= ~a;
	endtask
endmodule // far_side_model
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for the emulation map configuration block
// Assumes: zero wait apb slave, decode outputs one cycle after request
// Notes:   pins get three cycles to pass the synchroniser
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, cpu_addr_out, pci_mem_addr, rdat, cpu_addr;
	logic [31:0] pci_addr;
	logic        debug_config_bit, map_select, cpu_valid, cpu_to_pci;
	logic        cpu_out_valid, pci_valid, pci_write, pci_claim, irq;
	logic        programmable_irq_out, rerr;
	logic [1:0]  tracking_state;
	int          num_errors, check_count, cycles;

	emulation_map_config emulation_map_config_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.debug_config_bit(debug_config_bit), .map_select(map_select),
		.tracking_state(tracking_state), .cpu_valid(cpu_valid),
		.cpu_addr(cpu_addr), .cpu_addr_out(cpu_addr_out),
		.cpu_to_pci(cpu_to_pci), .cpu_out_valid(cpu_out_valid),
		.pci_valid(pci_valid), .pci_write(pci_write), .pci_addr(pci_addr),
		.pci_claim(pci_claim), .pci_mem_addr(pci_mem_addr),
		.programmable_irq_out(programmable_irq_out), .irq(irq));
	far_side_model far_side_model_i (.pclk(pclk), .cpu_valid(cpu_valid),
		.cpu_addr(cpu_addr), .pci_valid(pci_valid), .pci_write(pci_write),
		.pci_addr(pci_addr));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat, exp);
	endtask
	task automatic cpu(input logic [31:0] a, input logic [31:0] ea,
		input logic ep);
		far_side_model_i.cpu_req(a);
		#1;
		chk(cpu_addr_out, ea);
		chk({31'h0, cpu_to_pci}, {31'h0, ep});
		chk({31'h0, cpu_out_valid}, 32'h0000_0001);
	endtask
	task automatic pci(input logic [31:0] a, input logic wr, input logic ec,
		input logic [31:0] em, input logic ei);
		far_side_model_i.pci_req(a, wr);
		#1;
		chk({31'h0, pci_claim}, {31'h0, ec});
		if (ec)
			chk(pci_mem_addr, em);
		chk({31'h0, programmable_irq_out}, {31'h0, ei});
	endtask

	initial begin
		{presetn, psel, penable, pwrite, debug_config_bit, map_select} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		tracking_state = 2'b00;
		{num_errors, check_count, cycles} = 0;
		cyc(6);
		presetn <= 1'b1;
		cyc(3);
		rd(emulation_map_pkg::CFG_ONE_OFFSET, 32'h0fff_0042);
		rd(emulation_map_pkg::CFG_TWO_OFFSET, 32'h0000_0020);
		apb(1'b1, emulation_map_pkg::CFG_ONE_OFFSET, 32'hffff_ffff);
		rd(emulation_map_pkg::CFG_ONE_OFFSET, 32'h0fff_ff7f);
		apb(1'b1, emulation_map_pkg::CFG_TWO_OFFSET, 32'hffff_ff10);
		rd(emulation_map_pkg::CFG_TWO_OFFSET, 32'h0000_0010);
		rd(8'h40, 32'h0000_0000);
		chk({31'h0, rerr}, 32'h0000_0001);
		$display("test registers done");
		apb(1'b1, emulation_map_pkg::CFG_ONE_OFFSET, 32'h0123_1021);
		cpu(32'hfff1_2345, 32'h1231_2345, 1'b0);
		cpu(32'h000a_0000, 32'h000a_0000, 1'b0);
		pci(32'h0100_0000, 1'b0, 1'b1, 32'h0100_0000, 1'b1);
		pci(32'h0110_0000, 1'b0, 1'b0, 32'h0000_0000, 1'b1);
		pci(32'h000a_0000, 1'b1, 1'b1, 32'h000a_0000, 1'b0);
		rd(emulation_map_pkg::IRQ_STATUS_OFFSET, 32'h0000_0005);
		chk({31'h0, irq}, 32'h0000_0000);
		apb(1'b1, emulation_map_pkg::IRQ_MASK_OFFSET, 32'h0000_0001);
		cyc(2);
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b1, emulation_map_pkg::IRQ_STATUS_OFFSET, 32'h0000_0005);
		cyc(2);
		chk({31'h0, irq}, 32'h0000_0000);
		rd(emulation_map_pkg::IRQ_STATUS_OFFSET, 32'h0000_0000);
		$display("test emulation low done");
		apb(1'b1, emulation_map_pkg::CFG_ONE_OFFSET, 32'h0123_103d);
		cpu(32'h000b_ffff, 32'h000b_ffff, 1'b1);
		pci(32'h000a_0000, 1'b1, 1'b0, 32'h0000_0000, 1'b0);
		pci(32'h0000_1000, 1'b1, 1'b1, 32'h0000_1000, 1'b1);
		tracking_state <= 2'b01;
		cyc(3);
		pci(32'h0000_2000, 1'b1, 1'b1, 32'h0000_2000, 1'b0);
		$display("test emulation high done");
		debug_config_bit <= 1'b1;
		map_select <= 1'b1;
		apb(1'b1, emulation_map_pkg::CFG_ONE_OFFSET, 32'h0123_1041);
		cpu(32'hfff1_2345, 32'hfff1_2345, 1'b0);
		pci(32'hfd12_3456, 1'b0, 1'b1, 32'h0012_3456, 1'b1);
		apb(1'b1, emulation_map_pkg::CFG_ONE_OFFSET, 32'h0123_1001);
		pci(32'hfd12_3456, 1'b0, 1'b0, 32'h0000_0000, 1'b1);
		$display("test map b done");
		map_select <= 1'b0;
		apb(1'b1, emulation_map_pkg::CFG_ONE_OFFSET, 32'h0123_100d);
		cpu(32'h000a_0000, 32'h000a_0000, 1'b0);
		$display("test map a done");
		give_verdict();
	end
endmodule // tb
`default_nettype wire
